// File: logic/sbc_ctrl_pkg.sv
// Shared constants and types for the mode, supply and watchdog control registers
`default_nettype none
package sbc_ctrl_pkg;
  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned RW_BIT     = 7;
  // Register addresses (7-bit word addresses)
  localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] ADDR_HW_CONFIG   = 7'h02;
  localparam logic [6:0] ADDR_SUPERVISOR  = 7'h03;
  // ****************************************
  // Reset, write and restart masks
  // ****************************************
  localparam logic [7:0] RST_MODE_SUPPLY  = 8'h00;
  localparam logic [7:0] RST_HW_CONFIG    = 8'h00;
  localparam logic [7:0] RST_SUPERVISOR   = 8'h14;
  localparam logic [7:0] WMASK_HW_CONFIG  = 8'hFB;
  localparam logic [7:0] WMASK_SUPERVISOR = 8'hF7;
  localparam logic [7:0] SOFT_KEEP_HW     = 8'h88;
  localparam logic [7:0] RESTART_KEEP_MS  = 8'h23;
  localparam logic [7:0] RESTART_KEEP_HW  = 8'hD9;
  localparam logic [7:0] RESTART_KEEP_WD  = 8'hB0;
  localparam logic [7:0] RESTART_SET_WD   = 8'h04;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned MODE_HI      = 7;
  localparam int unsigned MODE_LO      = 6;
  localparam int unsigned THIRD_EN     = 5;
  localparam int unsigned SECOND_HI    = 4;
  localparam int unsigned SECOND_LO    = 3;
  localparam int unsigned OV_REACT     = 2;
  localparam int unsigned RST_MASK_BIT = 6;
  localparam int unsigned FO_SW_BIT    = 5;
  localparam int unsigned UV_KEEP_BIT  = 4;
  localparam int unsigned LS_BIT       = 3;
  localparam int unsigned LS_STOP_BIT  = 1;
  localparam int unsigned WD_STOP_DIS  = 6;
  localparam int unsigned WD_BUS_WAKE  = 4;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned SOFT_RST_LOW_NS   = 2000;
  localparam int unsigned SOFT_RST_LOW_CYC  =
    (SOFT_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_SLEEP = 2'b01, MODE_STOP = 2'b10, MODE_SOFT_RESET = 2'b11
  } op_mode_t;
  localparam logic [1:0] SECOND_OFF = 2'b00;
  localparam logic [1:0] SECOND_NORM = 2'b01;
  localparam logic [1:0] SECOND_NORM_STOP = 2'b10;
  typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_ADDR = 2'b01, SH_DATA = 2'b11} shift_state_t;
endpackage
`default_nettype wire

// File: logic/sbc_ctrl_regs.sv
// Mode/supply, hardware configuration and watchdog control registers behind the serial port
`default_nettype none
// Overview of operation
// - Mode field 7:6: 00 normal, 01 sleep, 10 stop, 11 soft reset.
// - A serial write cannot move the mode from stop to sleep.
// - Restart sets mode normal and second regulator off; overtemperature also clears it.
// - Second regulator: off, normal only, normal and stop, always except fail-safe.
// - Bit 5 enables the third regulator as independent regulator.
// - Overvoltage always sets flag; bit 2 also requests restart or fail-safe.
// - Bits 1:0 pick one of four main reset thresholds, 00 highest.
// - A write returns the register content held before that write.
// - Hardware bit 7 picks main voltage or lower fixed third regulator voltage.
// - Hardware bit 6 set suppresses the reset pin pulse on soft reset.
// - Hardware bit 5 drives failure outputs under software control.
// - Real failures hold failure outputs until the failure status clears.
// - Restart clears the software failure-output bit and releases the outputs.
// - Hardware bit 4 keeps third regulator on during supply undervoltage.
// - Hardware bit 3 selects stand-alone or load-sharing third regulator.
// - Hardware bit 1 allows load sharing in stop and high-power mode.
// - Hardware bit 0 selects first or second watchdog failure for restart.
// - Hardware register powers up zero; soft reset keeps bits 7 and 3.
// - Watchdog control byte must have even parity; odd writes are rejected.
// - Watchdog bit 6 set deactivates the watchdog in stop.
// - Watchdog bit 5 selects time-out or window operation.
// - Watchdog bit 4 starts watchdog after bus wake in stop.
// - A command is sixteen bits: address, access bit, data byte.
// - Serial bit 7 high writes, low only reads.
module sbc_ctrl_regs #(
  parameter int unsigned FO_COUNT = 3
) (
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                sys_rst_in,
  // Serial port
  input  wire logic                spi_cs_n_in,
  input  wire logic                spi_clk_in,
  input  wire logic                spi_sdi_in,
  output logic                     spi_sdo_out,
  output logic                     spi_sdo_oe_n_out,
  // Device events and conditions
  input  wire logic                restart_entry_in,
  input  wire logic                overtemp_in,
  input  wire logic                main_overvoltage_in,
  input  wire logic                ov_flag_clear_in,
  input  wire logic                failure_status_in,
  input  wire logic                fail_safe_in,
  input  wire logic                high_power_in,
  input  wire logic                supply_undervoltage_in,
  input  wire logic                bus_wake_in,
  // Register contents
  output logic [7:0]               mode_supply_out,
  output logic [7:0]               hw_config_out,
  output logic [7:0]               supervisor_out,
  // Derived controls
  output logic                     soft_reset_out,
  output logic                     reset_output_pin_n_out,
  output logic [FO_COUNT-1:0]      failure_output_pins_out,
  output logic                     main_overvoltage_flag_out,
  output logic                     ov_restart_req_out,
  output logic                     second_regulator_run_out,
  output logic                     third_regulator_run_out,
  output logic                     load_share_active_out,
  output logic                     watchdog_run_out,
  output logic                     watchdog_bus_start_out,
  output logic                     checksum_error_out
);
  localparam logic [7:0] LOW_CYC = 8'(sbc_ctrl_pkg::SOFT_RST_LOW_CYC);

  spi_frame_if fi ();
  logic [7:0] mode_supply;
  logic [7:0] hw_config;
  logic [7:0] supervisor;
  logic [7:0] low_cnt;
  logic       wr_ms;
  logic       wr_hw;
  logic       wr_wd;
  logic       soft_req;
  logic [1:0] mode;

  // Register selected by a frame address; unmapped addresses read zero
  function automatic logic [7:0] reg_select(input logic [6:0] a, input logic [7:0] ms,
                                            input logic [7:0] hw, input logic [7:0] wd);
    case (a)
      sbc_ctrl_pkg::ADDR_MODE_SUPPLY: reg_select = ms;
      sbc_ctrl_pkg::ADDR_HW_CONFIG:   reg_select = hw;
      sbc_ctrl_pkg::ADDR_SUPERVISOR:  reg_select = wd;
      default:                        reg_select = 8'h00;
    endcase
  endfunction

  // Mode after a write: stop cannot be left straight into sleep
  function automatic logic [1:0] next_mode(input logic [1:0] cur, input logic [1:0] req);
    if (cur == sbc_ctrl_pkg::MODE_STOP && req == sbc_ctrl_pkg::MODE_SLEEP) begin
      next_mode = cur;
    end else begin
      next_mode = req;
    end
  endfunction

  spi_frame_shifter u_shifter (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .cs_n_in      (spi_cs_n_in),
    .sclk_in      (spi_clk_in),
    .sdi_in       (spi_sdi_in),
    .sdo_out      (spi_sdo_out),
    .sdo_oe_n_out (spi_sdo_oe_n_out),
    .fi           (fi)
  );

  // ****************************************
  // Access decode
  // ****************************************
  // Reads see the stored value; writes commit only at frame end
  assign fi.rdata = reg_select(fi.addr, mode_supply, hw_config, supervisor);
  assign wr_ms    = fi.done && fi.wr && fi.addr == sbc_ctrl_pkg::ADDR_MODE_SUPPLY;
  assign wr_hw    = fi.done && fi.wr && fi.addr == sbc_ctrl_pkg::ADDR_HW_CONFIG;
  assign wr_wd    = fi.done && fi.wr && fi.addr == sbc_ctrl_pkg::ADDR_SUPERVISOR;
  assign soft_req = wr_ms && !restart_entry_in &&
                    fi.wdata[sbc_ctrl_pkg::MODE_HI:sbc_ctrl_pkg::MODE_LO]
                    == sbc_ctrl_pkg::MODE_SOFT_RESET;
  assign mode     = mode_supply[sbc_ctrl_pkg::MODE_HI:sbc_ctrl_pkg::MODE_LO];
  assign mode_supply_out = mode_supply;
  assign hw_config_out   = hw_config;
  assign supervisor_out  = supervisor;

  // ****************************************
  // Registers
  // ****************************************
  // Mode and supply: restart beats a write, overtemperature acts after the write
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_supply <= sbc_ctrl_pkg::RST_MODE_SUPPLY;
    end else if (restart_entry_in) begin
      mode_supply <= mode_supply & sbc_ctrl_pkg::RESTART_KEEP_MS;
    end else if (soft_req) begin
      mode_supply <= sbc_ctrl_pkg::RST_MODE_SUPPLY;
    end else begin
      if (wr_ms) begin
        mode_supply <= {next_mode(mode, fi.wdata[7:6]), fi.wdata[5:0]};
      end
      if (overtemp_in) begin
        mode_supply[sbc_ctrl_pkg::SECOND_HI:sbc_ctrl_pkg::SECOND_LO] <=
          sbc_ctrl_pkg::SECOND_OFF;
      end
    end
  end

  // Hardware configuration; soft reset keeps the third regulator shape bits
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hw_config <= sbc_ctrl_pkg::RST_HW_CONFIG;
    end else if (restart_entry_in) begin
      hw_config <= hw_config & sbc_ctrl_pkg::RESTART_KEEP_HW;
    end else if (soft_req) begin
      hw_config <= hw_config & sbc_ctrl_pkg::SOFT_KEEP_HW;
    end else if (wr_hw) begin
      hw_config <= fi.wdata & sbc_ctrl_pkg::WMASK_HW_CONFIG;
    end
  end

  // Watchdog control; a byte with odd parity is dropped whole
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      supervisor         <= sbc_ctrl_pkg::RST_SUPERVISOR;
      checksum_error_out <= 1'b0;
    end else begin
      checksum_error_out <= wr_wd && (^fi.wdata) && !restart_entry_in && !soft_req;
      if (restart_entry_in) begin
        supervisor <= (supervisor & sbc_ctrl_pkg::RESTART_KEEP_WD) | sbc_ctrl_pkg::RESTART_SET_WD;
      end else if (soft_req) begin
        supervisor <= sbc_ctrl_pkg::RST_SUPERVISOR;
      end else if (wr_wd && !(^fi.wdata)) begin
        supervisor <= fi.wdata & sbc_ctrl_pkg::WMASK_SUPERVISOR;
      end
    end
  end

  // ****************************************
  // Soft reset and reset pin
  // ****************************************
  // The pin mask is taken from the value held before the reset clears it
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_cnt                <= 8'h00;
      soft_reset_out         <= 1'b0;
      reset_output_pin_n_out <= 1'b1;
    end else begin
      soft_reset_out <= soft_req;
      if (soft_req && !hw_config[sbc_ctrl_pkg::RST_MASK_BIT]) begin
        low_cnt <= LOW_CYC;
      end else if (low_cnt != 8'h00) begin
        low_cnt <= low_cnt - 8'h01;
      end
      reset_output_pin_n_out <= (low_cnt == 8'h00);
    end
  end

  // ****************************************
  // Supply, failure and watchdog controls
  // ****************************************
  // Overvoltage flag: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_overvoltage_flag_out <= 1'b0;
      ov_restart_req_out        <= 1'b0;
    end else begin
      if (main_overvoltage_in) begin
        main_overvoltage_flag_out <= 1'b1;
      end else if (ov_flag_clear_in) begin
        main_overvoltage_flag_out <= 1'b0;
      end
      ov_restart_req_out <= main_overvoltage_in && mode_supply[sbc_ctrl_pkg::OV_REACT];
    end
  end

  // Regulator enables from policy fields and the current mode
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      second_regulator_run_out <= 1'b0;
      third_regulator_run_out  <= 1'b0;
      load_share_active_out    <= 1'b0;
    end else begin
      case (mode_supply[sbc_ctrl_pkg::SECOND_HI:sbc_ctrl_pkg::SECOND_LO])
        sbc_ctrl_pkg::SECOND_OFF:       second_regulator_run_out <= 1'b0;
        sbc_ctrl_pkg::SECOND_NORM:      second_regulator_run_out <= mode == sbc_ctrl_pkg::MODE_NORMAL;
        sbc_ctrl_pkg::SECOND_NORM_STOP: second_regulator_run_out <=
          mode == sbc_ctrl_pkg::MODE_NORMAL || mode == sbc_ctrl_pkg::MODE_STOP;
        default:                        second_regulator_run_out <= !fail_safe_in;
      endcase
      third_regulator_run_out <= mode_supply[sbc_ctrl_pkg::THIRD_EN] &&
        (!supply_undervoltage_in || hw_config[sbc_ctrl_pkg::UV_KEEP_BIT]);
      load_share_active_out <= mode_supply[sbc_ctrl_pkg::THIRD_EN] &&
        hw_config[sbc_ctrl_pkg::LS_BIT] &&
        (!(mode == sbc_ctrl_pkg::MODE_STOP || high_power_in) ||
         hw_config[sbc_ctrl_pkg::LS_STOP_BIT]);
    end
  end

  // Failure outputs follow software request or a real failure
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      failure_output_pins_out <= '0;
    end else begin
      failure_output_pins_out <= {FO_COUNT{hw_config[sbc_ctrl_pkg::FO_SW_BIT]
                                           || failure_status_in}};
    end
  end

  // Watchdog gating in stop and start on bus wake
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      watchdog_run_out       <= 1'b1;
      watchdog_bus_start_out <= 1'b0;
    end else begin
      watchdog_run_out <= !(mode == sbc_ctrl_pkg::MODE_STOP &&
                            supervisor[sbc_ctrl_pkg::WD_STOP_DIS]);
      watchdog_bus_start_out <= bus_wake_in && mode == sbc_ctrl_pkg::MODE_STOP &&
                                supervisor[sbc_ctrl_pkg::WD_BUS_WAKE];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  stop_to_sleep_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_ms && !restart_entry_in && mode == sbc_ctrl_pkg::MODE_STOP &&
    fi.wdata[7:6] == sbc_ctrl_pkg::MODE_SLEEP |=> mode == sbc_ctrl_pkg::MODE_STOP)
    else $error("stop went straight to sleep");
  restart_mode_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    restart_entry_in |=> mode == sbc_ctrl_pkg::MODE_NORMAL &&
    mode_supply[sbc_ctrl_pkg::SECOND_HI:sbc_ctrl_pkg::SECOND_LO] == sbc_ctrl_pkg::SECOND_OFF)
    else $error("restart left mode or second regulator set");
  restart_fo_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    restart_entry_in && !failure_status_in ##1 !failure_status_in |=> failure_output_pins_out == '0)
    else $error("failure outputs held after restart");
  soft_keep_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    soft_req |=> hw_config == ($past(hw_config) & sbc_ctrl_pkg::SOFT_KEEP_HW) &&
    supervisor == sbc_ctrl_pkg::RST_SUPERVISOR ##1 soft_reset_out == 1'b0)
    else $error("soft reset register values wrong");
  reset_pulse_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    soft_req && !hw_config[sbc_ctrl_pkg::RST_MASK_BIT] |=> ##1 !reset_output_pin_n_out [*8])
    else $error("reset pin pulse missing");
  ov_reaction_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    main_overvoltage_in |=> main_overvoltage_flag_out &&
    ov_restart_req_out == $past(mode_supply[sbc_ctrl_pkg::OV_REACT]))
    else $error("overvoltage reaction wrong");
  parity_reject_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_wd && (^fi.wdata) && !restart_entry_in && !soft_req |=> $stable(supervisor) &&
    checksum_error_out)
    else $error("odd parity byte accepted");
  reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    hw_config[2] == 1'b0 && supervisor[3] == 1'b0)
    else $error("reserved bit set");
  failure_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    failure_status_in |=> failure_output_pins_out == {FO_COUNT{1'b1}})
    else $error("failure outputs released during failure");
  uv_shutdown_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    supply_undervoltage_in && !hw_config[sbc_ctrl_pkg::UV_KEEP_BIT] |=> !third_regulator_run_out)
    else $error("third regulator kept on at undervoltage");
endmodule
`default_nettype wire

// File: logic/spi_frame_if.sv
// Decoded serial frame passed from the shifter to the register bank
`default_nettype none
interface spi_frame_if;
  logic [6:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic       done;
  logic       addr_valid;
  logic [7:0] rdata;
  modport shifter (output addr, wr, wdata, done, addr_valid, input rdata);
  modport regs (input addr, wr, wdata, done, addr_valid, output rdata);
endinterface
`default_nettype wire

// File: logic/spi_frame_shifter.sv
// Serial shifter: 16-bit frames, LSB first, sampled on rising and driven on falling clock
`default_nettype none
module spi_frame_shifter (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // Serial pins
  input  wire logic cs_n_in,
  input  wire logic sclk_in,
  input  wire logic sdi_in,
  output logic      sdo_out,
  output logic      sdo_oe_n_out,
  // Decoded frame
  spi_frame_if.shifter fi
);
  sbc_ctrl_pkg::shift_state_t state;
  logic        sclk_q;
  logic        cs_n_q;
  logic [4:0]  bit_cnt;
  logic [15:0] frame;
  logic [7:0]  tx;
  logic        done_q;
  logic        addr_valid_q;
  logic        rise;
  logic        fall;
  localparam logic [4:0] CNT_FULL = 5'(sbc_ctrl_pkg::FRAME_BITS);
  localparam logic [4:0] CNT_RW   = 5'(sbc_ctrl_pkg::RW_BIT);

  // Edge detection; pins are already synchronous to the clock
  assign rise = !cs_n_in && sclk_in && !sclk_q;
  assign fall = !cs_n_in && !sclk_in && sclk_q;
  assign fi.addr       = frame[6:0];
  assign fi.wr         = frame[sbc_ctrl_pkg::RW_BIT];
  assign fi.wdata      = frame[15:8];
  assign fi.done       = done_q;
  assign fi.addr_valid = addr_valid_q;

  // Edge history
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_in;
      cs_n_q <= cs_n_in;
    end
  end

  // Bit capture; bits past the sixteenth are ignored
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt      <= 5'h00;
      frame        <= 16'h0000;
      addr_valid_q <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      addr_valid_q <= rise && (bit_cnt == CNT_RW);
      // Only a full-length frame commits when chip select rises
      done_q       <= cs_n_in && !cs_n_q && (bit_cnt == CNT_FULL);
      if (cs_n_in) begin
        bit_cnt <= 5'h00;
      end else if (rise && bit_cnt != CNT_FULL) begin
        frame[bit_cnt[3:0]] <= sdi_in;
        bit_cnt             <= bit_cnt + 5'h01;
      end
    end
  end

  // Phase tracking
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= sbc_ctrl_pkg::SH_IDLE;
    end else if (cs_n_in) begin
      state <= sbc_ctrl_pkg::SH_IDLE;
    end else begin
      case (state)
        sbc_ctrl_pkg::SH_IDLE: state <= sbc_ctrl_pkg::SH_ADDR;
        sbc_ctrl_pkg::SH_ADDR: if (addr_valid_q) state <= sbc_ctrl_pkg::SH_DATA;
        sbc_ctrl_pkg::SH_DATA: state <= sbc_ctrl_pkg::SH_DATA;
        default:               state <= sbc_ctrl_pkg::SH_IDLE;
      endcase
    end
  end

  // Read byte is latched once the address is known, before any write commits
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx           <= 8'h00;
      sdo_out      <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else begin
      sdo_oe_n_out <= cs_n_in;
      if (cs_n_in) begin
        sdo_out <= 1'b0;
      end else if (addr_valid_q) begin
        tx <= fi.rdata;
      end else if (fall && state == sbc_ctrl_pkg::SH_DATA) begin
        sdo_out <= tx[0];
        tx      <= {1'b0, tx[7:1]};
      end
    end
  end

  frame_length_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    done_q |-> $past(bit_cnt) == CNT_FULL && $rose(cs_n_q))
    else $error("frame committed without sixteen bits");
endmodule
`default_nettype wire

// File: tb/spi_master_model.sv
// Serial master model: sends 16-bit frames and collects the answer byte
`default_nettype none
module spi_master_model (
  // Clock
  input  wire logic ref_clk_in,
  // Serial pins
  input  wire logic sdo_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cs_n_out, sclk_out, sdi_out} = 3'b100;
  // LSB first, four ref cycles per serial half period so the sampler never misses an edge
  task automatic frame(input logic [15:0] f, output logic [7:0] q);
    @(negedge ref_clk_in) cs_n_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi_out = f[i];
      sclk_out = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      if (i > 7) q[i-8] = sdo_in;
      sclk_out = 1'b1;
      repeat (4) @(negedge ref_clk_in);
    end
    sclk_out = 1'b0;
    sdi_out = ~sdi_out; // Stale data is not left on the wire
    repeat (4) @(negedge ref_clk_in);
    cs_n_out = 1'b1;
    repeat (6) @(negedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the control register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       cs_n, sclk, sdi, sdo, rst_ev, ov, fst, uv, ovf, ot, srst, rpn, cerr;
  logic [3:0] run;
  logic [7:0] n_cerr = 8'h00, n_soft = 8'h00, n_odd = 8'h00;
  logic [7:0] ms, hw, wd, q, d, e_ms, e_hw, e_wd;
  logic [2:0] fo;
  int         fail_count = 0;
  int         compares = 0;
  int         seed = 60;
  // 25 MHz clock
  always #20 ref_clk_in = ~ref_clk_in;
  spi_master_model mst_u (.ref_clk_in(ref_clk_in), .sdo_in(sdo), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi));
  sbc_ctrl_regs dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .spi_cs_n_in(cs_n),
    .spi_clk_in(sclk), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_n_out(),
    .restart_entry_in(rst_ev), .overtemp_in(ot), .main_overvoltage_in(ov),
    .ov_flag_clear_in(1'b0), .failure_status_in(fst), .fail_safe_in(1'b0),
    .high_power_in(1'b0), .supply_undervoltage_in(uv), .bus_wake_in(1'b0),
    .mode_supply_out(ms), .hw_config_out(hw), .supervisor_out(wd), .soft_reset_out(srst),
    .reset_output_pin_n_out(rpn), .failure_output_pins_out(fo),
    .main_overvoltage_flag_out(ovf), .ov_restart_req_out(), .second_regulator_run_out(run[3]),
    .third_regulator_run_out(run[2]), .load_share_active_out(run[1]), .watchdog_run_out(run[0]),
    .watchdog_bus_start_out(), .checksum_error_out(cerr));
  // Stop cannot become sleep by a write; the rest of the byte still lands
  function automatic logic [7:0] ms_next(logic [7:0] c, logic [7:0] v);
    return (c[7:6] == 2'b10 && v[7:6] == 2'b01) ? {2'b10, v[5:0]} : v;
  endfunction
  // Enables the policy bits call for, with fail-safe and high power held low
  function automatic logic [7:0] run_exp(logic [7:0] m, logic [7:0] h, logic [7:0] w, logic u);
    logic s;
    s = (m[4:3] == 2'b11) || (m[4:3] == 2'b01 && m[7:6] == 2'b00) ||
        (m[4:3] == 2'b10 && (m[7:6] == 2'b00 || m[7:6] == 2'b10));
    return {4'h0, s, m[5] && (!u || h[4]), m[5] && h[3] && (m[7:6] != 2'b10 || h[1]),
            !(m[7:6] == 2'b10 && w[6])};
  endfunction
  // One-cycle pulses are counted at the falling edge, where they have settled
  always @(negedge ref_clk_in) begin
    if (cerr === 1'b1)
      n_cerr++;
    if (srst === 1'b1)
      n_soft++;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write frame; the answer is the content held before it
  task automatic wr(logic [6:0] a, logic [7:0] v, logic [7:0] e);
    mst_u.frame({v, 1'b1, a}, q);
    chk("answer", e, q);
  endtask
  task automatic stop_test;
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #2400000;
    fail_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    {rst_ev, ov, fst, uv, ot} = 5'h00;
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in) sys_rst_in = 1'b0;
    {e_ms, e_hw, e_wd} = {8'h00, 8'h00, 8'h14};
    chk("hw", e_hw, hw);
    chk("wd", e_wd, wd);
    // Stop then a sleep request first, random bytes after; soft reset kept out
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'hA1 : (i == 1) ? 8'h47 : 8'($random(seed));
      d[7] = d[7] & ~d[6];
      uv = d[0];
      wr(7'h01, d, e_ms);
      e_ms = ms_next(e_ms, d);
      chk("ms", e_ms, ms);
      d = 8'($random(seed));
      wr(7'h02, d, e_hw);
      e_hw = d & 8'hFB;
      chk("hw", e_hw, hw);
      d = 8'($random(seed)) & 8'hF7;
      wr(7'h03, d, e_wd);
      if (~^d)
        e_wd = d;
      else
        n_odd++;
      chk("wd", e_wd, wd);
      chk("run", run_exp(e_ms, e_hw, e_wd, uv), {4'h0, run});
    end
    chk("cksum", n_odd, n_cerr);
    mst_u.frame({8'h00, 1'b0, 7'h40}, q);
    chk("unmapped", 8'h00, q);
    mst_u.frame({8'hFF, 1'b0, 7'h02}, q);
    chk("answer", e_hw, q);
    chk("hw", e_hw, hw);
    // Software activation; a real failure holds the pins after the bit clears
    wr(7'h02, 8'hFB, e_hw);
    chk("fo", 8'h07, {5'h0, fo});
    fst = 1'b1;
    wr(7'h02, 8'hDB, 8'hFB);
    chk("fo", 8'h07, {5'h0, fo});
    fst = 1'b0;
    wr(7'h02, 8'hFB, 8'hDB);
    @(negedge ref_clk_in) rst_ev = 1'b1;
    @(negedge ref_clk_in) rst_ev = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk("ms", e_ms & 8'h23, ms);
    chk("hw", 8'hD9, hw);
    chk("fo", 8'h00, {5'h0, fo});
    chk("wd", (e_wd & 8'hB0) | 8'h04, wd);
    @(negedge ref_clk_in) ov = 1'b1;
    @(negedge ref_clk_in) ov = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk("ovflag", 8'h01, {7'h0, ovf});
    // Pin pulse left enabled; soft reset keeps only the two third-regulator setup bits
    wr(7'h02, 8'h8A, 8'hD9);
    wr(7'h01, 8'hC0, e_ms & 8'h23);
    repeat (2) @(negedge ref_clk_in);
    chk("ms", 8'h00, ms);
    chk("hw", 8'h88, hw);
    chk("wd", 8'h14, wd);
    chk("softpulse", 8'h01, n_soft);
    chk("rstpin", 8'h00, {7'h0, rpn});
    repeat (sbc_ctrl_pkg::SOFT_RST_LOW_CYC) @(negedge ref_clk_in);
    chk("rstpin", 8'h01, {7'h0, rpn});
    // Overtemperature clears only the second regulator field
    wr(7'h01, 8'h3B, 8'h00);
    @(negedge ref_clk_in) ot = 1'b1;
    @(negedge ref_clk_in) ot = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk("ms", 8'h23, ms);
    stop_test();
  end
endmodule
`default_nettype wire
